// ===== shared/cell_mem_pkg.sv
// Constants and types shared by the cell memory control and receive ports.
// Assumes a single system clock domain plus one clock per input port.
`default_nettype none
package cell_mem_pkg;
  localparam int CMD_W = 6;
  localparam int DATA_W = 32;
  localparam int PORTS = 8;
  localparam int NIB_W = 4;
  localparam int HDR_W = 40;
  localparam int LEN_W = 7;
  localparam int CFG_LINK_W = 10;
  // System clock figures
  localparam int SCLK_PERIOD_NS = 8;
  localparam int SCLK_MAX_NS = 200;
  localparam int SCLK_MAX_CYCLES = SCLK_MAX_NS / SCLK_PERIOD_NS;
  // Command codes
  localparam logic [5:0] CMD_NOP = 6'h00;
  localparam logic [5:0] CMD_STORE = 6'h01;
  localparam logic [5:0] CMD_LOAD = 6'h02;
  localparam logic [5:0] CMD_WR_CONFIG = 6'h03;
  localparam logic [5:0] CMD_RD_STATUS = 6'h04;
  localparam logic [5:0] CMD_HDR_CRC = 6'h05;
  // Configuration word layout
  localparam int CFG_PORT_EN_LSB = 0;
  localparam int CFG_LEN_LSB = 8;
  localparam int CFG_NARROW_BIT = 12;
  localparam int CFG_CHIP_ID_LSB = 26;
  localparam int CFG_CTL_OFF_BIT = 31;
  localparam logic [31:0] CFG_RESET = 32'h8000_01FF;
  // Bus fields carrying the addressed chip id after store/load and the port for a header check
  localparam int BUS_ID_LSB = 13;
  localparam int BUS_PORT_LSB = 0;
  // Status word layout
  localparam int STAT_FULL_BIT = 0;
  localparam int STAT_EMPTY_BIT = 1;
  localparam int STAT_PEND_LSB = 8;
  localparam int STAT_BUSY_LSB = 16;
  // Cell geometry
  localparam logic [6:0] CELL_BYTES_MIN = 7'h34;
  localparam logic [2:0] CELL_CODE_MAX = 3'h4;
  localparam logic [6:0] HDR_NIBBLES = 7'h0A;
  localparam logic [6:0] DUMMY_NIB_POS = 7'h10;
  localparam logic [6:0] IDX_STEP = 7'h01;
  localparam logic [6:0] IDX_SKIP = 7'h03;
  localparam logic [7:0] HEC_POLY = 8'h07;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CHECK = 3'b010,
    ST_CONFIG = 3'b100
  } ctl_state_t;
endpackage
`default_nettype wire

// ===== rtl/input_port_rx.sv
// One receive port: samples frame and nibbles on its own port clock.
// Assumes config inputs are quasi-static; they are resynchronised here.
`default_nettype none
module input_port_rx (
  input wire logic port_clk,
  input wire logic sys_rst,
  input wire logic frame,
  input wire logic [cell_mem_pkg::NIB_W-1:0] nibble,
  input wire logic [cell_mem_pkg::CFG_LINK_W-1:0] link_cfg,
  output logic start_toggle,
  output logic done_toggle,
  output logic [cell_mem_pkg::HDR_W-1:0] header_word
);
  import cell_mem_pkg::*;

  logic [1:0] rst_pipe;
  logic [CFG_LINK_W-1:0] cfg_meta;
  logic [CFG_LINK_W-1:0] cfg_sync;
  logic frame_q;
  logic [NIB_W-1:0] nib_q;
  logic active;
  logic [LEN_W-1:0] wr_idx;
  logic [HDR_W-1:0] hdr_shift;

  // Release of reset follows this port clock, which may be stopped
  always_ff @(posedge port_clk or posedge sys_rst) begin
    if (sys_rst) rst_pipe <= 2'h3;
    else rst_pipe <= {rst_pipe[0], 1'b0};
  end
  wire port_rst = rst_pipe[1];

  always_ff @(posedge port_clk or posedge port_rst) begin
    if (port_rst) begin
      cfg_meta <= '0;
      cfg_sync <= '0;
    end else begin
      cfg_meta <= link_cfg; // R3
      cfg_sync <= cfg_meta;
    end
  end

  wire port_en = cfg_sync[9];
  wire narrow = cfg_sync[8];
  wire dummy_pin = cfg_sync[7];
  wire [LEN_W-1:0] cell_len = cfg_sync[LEN_W-1:0];
  wire start = frame_q & port_en; // R17
  wire insert = narrow & dummy_pin;
  wire skip_dummy = insert && (wr_idx == DUMMY_NIB_POS - IDX_STEP); // R20
  wire [LEN_W-1:0] step = skip_dummy ? IDX_SKIP : IDX_STEP;
  wire last = active && (wr_idx + step >= cell_len); // R22

  always_ff @(posedge port_clk or posedge port_rst) begin
    if (port_rst) begin
      frame_q <= 1'b0;
      nib_q <= '0;
    end else begin
      frame_q <= frame; // R15
      nib_q <= nibble;
    end
  end

  // A stopped clock simply freezes the count, so a paused cell resumes
  always_ff @(posedge port_clk or posedge port_rst) begin
    if (port_rst) begin
      active <= 1'b0;
      wr_idx <= '0;
      start_toggle <= 1'b0;
      done_toggle <= 1'b0;
      hdr_shift <= '0;
      header_word <= '0;
    end else if (start) begin
      active <= 1'b1; // R16
      wr_idx <= '0;
      start_toggle <= ~start_toggle;
    end else if (active) begin
      wr_idx <= wr_idx + step; // R22
      if (wr_idx < HDR_NIBBLES) hdr_shift <= {hdr_shift[HDR_W-NIB_W-1:0], nib_q};
      if (last) begin
        active <= 1'b0;
        done_toggle <= ~done_toggle;
        header_word <= hdr_shift; // R21
      end
    end
  end

  chk_frame_restart: assert property ( // R17
    @(posedge port_clk) disable iff (port_rst) start |=> active && wr_idx == '0)
    else $error("frame strobe did not restart the cell");
  chk_dummy_skip: assert property ( // R20
    @(posedge port_clk) disable iff (port_rst)
    active && !start && skip_dummy |=> wr_idx == DUMMY_NIB_POS - IDX_STEP + IDX_SKIP)
    else $error("dummy byte position not skipped");
endmodule
`default_nettype wire

// ===== rtl/cell_switch_memory_ports.sv
// Control command port and eight receive ports of the cell memory.
// Assumes the controller runs on ref_clk; port clocks are unrelated.
`default_nettype none
// Overview of operation
// R1 - Control signals timed by ref_clk, except enables
// R2 - Controller keeps system clock period within limit
// R3 - Port signals crossed safely into system clock
// R4 - Command runs only with chip select low
// R5 - Six-bit command bus, bit five most significant
// R6 - Output enable high floats every output asynchronously; cell and memory cycle outputs stay driven
// R7 - Control-off bit or pin floats control outputs
// R8 - Reset high initialises everything asynchronously
// R9 - Controller holds reset and enable during power-up
// R10 - Store/load runs only when chip id matches
// R11 - Full always cleared; empty cleared only on match
// R12 - Four chip id pins, bit three most significant
// R13 - Thirty-two bit control data bus, synchronous
// R14 - Error flag low after header with bad check
// R15 - Each port samples on its own clock
// R16 - Stopped port clock pauses, restart resumes cell
// R17 - Frame strobe high starts a new cell
// R18 - Eight nibble ports, bit three most significant
// R19 - Control outputs need all three enables low
// R20 - Narrow mode inserts dummy byte at ninth position
// R21 - Port events synchronised before command logic uses
// R22 - Count nibbles per port clock to cell length
module cell_switch_memory_ports (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic chip_select_n,
  input wire logic [cell_mem_pkg::CMD_W-1:0] command_bus,
  input wire logic [cell_mem_pkg::DATA_W-1:0] control_data_in,
  output logic [cell_mem_pkg::DATA_W-1:0] control_data_out,
  output logic control_data_oe,
  output logic header_check_error_n,
  output logic header_check_error_oe,
  input wire logic output_enable_n,
  input wire logic control_output_enable_n,
  input wire logic [3:0] chip_id_pins,
  input wire logic [cell_mem_pkg::PORTS-1:0] input_port_clock,
  input wire logic [cell_mem_pkg::PORTS-1:0] input_cell_frame,
  input wire logic [cell_mem_pkg::PORTS*cell_mem_pkg::NIB_W-1:0] input_nibble_data,
  input wire logic add_dummy_byte,
  output logic cell_full,
  output logic cell_empty,
  output logic memory_cycle_go,
  output logic memory_cycle_load
);
  import cell_mem_pkg::*;

  ctl_state_t state;
  ctl_state_t next_state;
  logic [DATA_W-1:0] config_word;
  logic [3:0] id_meta;
  logic [3:0] id_sync;
  logic cycle_is_load;
  logic drive_data;
  logic last_store;
  logic [PORTS-1:0] pending;
  logic [PORTS-1:0] rx_busy;
  logic [PORTS-1:0] start_tog;
  logic [PORTS-1:0] done_tog;
  logic [PORTS-1:0] start_pulse;
  logic [PORTS-1:0] done_pulse;
  logic [HDR_W-1:0] link_header [PORTS];
  logic [HDR_W-1:0] hdr_hold [PORTS];

  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    c = '0;
    for (int i = 31; i >= 0; i--) begin
      if (c[7] ^ d[i]) c = {c[6:0], 1'b0} ^ HEC_POLY;
      else c = {c[6:0], 1'b0};
    end
    return c;
  endfunction

  function automatic logic [LEN_W-1:0] cell_nibbles(input logic [2:0] code);
    logic [LEN_W-1:0] bytes;
    bytes = CELL_BYTES_MIN + {4'h0, (code > CELL_CODE_MAX) ? CELL_CODE_MAX : code};
    return {bytes[LEN_W-2:0], 1'b0};
  endfunction

  // Receive ports and their event crossings
  wire [LEN_W-1:0] len_nibbles = cell_nibbles(config_word[CFG_LEN_LSB +: 3]);

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    logic [2:0] start_sync;
    logic [2:0] done_sync;

    input_port_rx u_rx (
      .port_clk(input_port_clock[p]), // R15
      .sys_rst(sys_rst),
      .frame(input_cell_frame[p]),
      .nibble(input_nibble_data[p*NIB_W +: NIB_W]), // R18
      .link_cfg({config_word[CFG_PORT_EN_LSB + p], config_word[CFG_NARROW_BIT],
        add_dummy_byte, len_nibbles}),
      .start_toggle(start_tog[p]),
      .done_toggle(done_tog[p]),
      .header_word(link_header[p])
    );

    // Toggle crossings; third stage only feeds the edge compare
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        start_sync <= '0;
        done_sync <= '0;
      end else begin
        start_sync <= {start_sync[1:0], start_tog[p]}; // R21
        done_sync <= {done_sync[1:0], done_tog[p]};
      end
    end
    assign start_pulse[p] = start_sync[2] ^ start_sync[1];
    assign done_pulse[p] = done_sync[2] ^ done_sync[1];

    // Header is held stable in the port domain until the next cell ends
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) hdr_hold[p] <= '0;
      else if (done_pulse[p]) hdr_hold[p] <= link_header[p]; // R3
    end
  end

  // Chip id pins are board straps, still resynchronised
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      id_meta <= '0;
      id_sync <= '0;
    end else begin
      id_meta <= chip_id_pins; // R12
      id_sync <= id_meta;
    end
  end

  // Command decode
  wire cmd_valid = ~chip_select_n && (state == ST_IDLE); // R4
  wire is_store = cmd_valid && (command_bus == CMD_STORE); // R5
  wire is_load = cmd_valid && (command_bus == CMD_LOAD);
  wire is_wr_cfg = cmd_valid && (command_bus == CMD_WR_CONFIG);
  wire is_rd_stat = cmd_valid && (command_bus == CMD_RD_STATUS);
  wire is_hdr_crc = cmd_valid && (command_bus == CMD_HDR_CRC);
  wire in_check = (state == ST_CHECK);

  wire [3:0] chip_id = id_sync | config_word[CFG_CHIP_ID_LSB +: 4];
  wire id_match = (chip_id == control_data_in[BUS_ID_LSB +: 4]); // R10
  wire check_hit = in_check && id_match;
  wire store_hit = check_hit && !cycle_is_load;

  wire [2:0] hdr_sel = control_data_in[BUS_PORT_LSB +: 3];
  wire [HDR_W-1:0] sel_header = hdr_hold[hdr_sel];
  wire crc_ok = (crc8(sel_header[HDR_W-1:8]) == sel_header[7:0]);

  // Lowest pending port is the one a matched store consumes
  wire [PORTS-1:0] store_clear = store_hit ? (pending & (~pending + 8'h01)) : '0;
  wire [PORTS-1:0] next_pending = (pending & ~store_clear) | done_pulse;
  wire [PORTS-1:0] next_busy = (rx_busy & ~done_pulse) | start_pulse;

  // Hardware set wins over a clear in the same cycle
  wire next_full = (|done_pulse) | (cell_full & ~in_check); // R11
  wire empty_set = last_store && (pending == '0);
  wire next_empty = empty_set | (cell_empty & ~check_hit); // R11

  wire [DATA_W-1:0] status_word = {8'h00, rx_busy, pending, 6'h00, cell_empty, cell_full};

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (is_store || is_load) next_state = ST_CHECK;
        else if (is_wr_cfg) next_state = ST_CONFIG;
      end
      ST_CHECK: next_state = ST_IDLE;
      ST_CONFIG: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) state <= ST_IDLE; // R8
    else state <= next_state;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) config_word <= CFG_RESET;
    else if (state == ST_CONFIG) config_word <= control_data_in; // R13
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) cycle_is_load <= 1'b0;
    else if (is_store || is_load) cycle_is_load <= is_load; // R1
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      memory_cycle_go <= 1'b0;
      memory_cycle_load <= 1'b0;
      last_store <= 1'b0;
    end else begin
      memory_cycle_go <= check_hit; // R10
      memory_cycle_load <= check_hit && cycle_is_load;
      last_store <= store_hit;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pending <= '0;
      rx_busy <= '0;
      cell_full <= 1'b0;
      cell_empty <= 1'b1;
    end else begin
      pending <= next_pending;
      rx_busy <= next_busy;
      cell_full <= next_full;
      cell_empty <= next_empty;
    end
  end

  // Read answers appear the cycle after the command
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      control_data_out <= '0;
      drive_data <= 1'b0;
    end else begin
      drive_data <= is_rd_stat || is_hdr_crc; // R13
      if (is_rd_stat) control_data_out <= status_word;
      else if (is_hdr_crc) control_data_out <= sel_header[HDR_W-1:8];
    end
  end

  // Flag holds until the next header check
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) header_check_error_n <= 1'b1;
    else if (is_hdr_crc) header_check_error_n <= crc_ok; // R14
  end

  // Enables are asynchronous by nature, so they gate the registered drive
  wire ctl_enabled = ~output_enable_n & ~control_output_enable_n &
    ~config_word[CFG_CTL_OFF_BIT]; // R19
  assign control_data_oe = drive_data & ctl_enabled; // R7
  assign header_check_error_oe = ctl_enabled; // R6

  // Checks
  sequence s_cfg_cmd;
    is_wr_cfg;
  endsequence

  sequence s_cfg_data;
    ##1 (state == ST_CONFIG);
  endsequence

  sequence s_hdr_cmd;
    is_hdr_crc;
  endsequence

  chk_reset_idle: assert property ( // R8
    @(posedge ref_clk) sys_rst |-> state == ST_IDLE && !cell_full && !memory_cycle_go)
    else $error("reset did not initialise control state");

  chk_nop_deselect: assert property ( // R4
    @(posedge ref_clk) disable iff (sys_rst)
    state == ST_IDLE && chip_select_n |=> state == ST_IDLE ##1 !memory_cycle_go)
    else $error("deselected cycle was not a no-operation");

  chk_cfg_write: assert property ( // R13
    @(posedge ref_clk) disable iff (sys_rst)
    s_cfg_cmd ##0 s_cfg_data |=> config_word == $past(control_data_in))
    else $error("configuration word not taken one cycle after command");

  chk_id_match_go: assert property ( // R10
    @(posedge ref_clk) disable iff (sys_rst)
    (is_store || is_load) ##1 id_match |=> memory_cycle_go)
    else $error("matched store or load did not run");

  chk_id_miss_stop: assert property ( // R10
    @(posedge ref_clk) disable iff (sys_rst)
    (is_store || is_load) ##1 !id_match |=> !memory_cycle_go)
    else $error("mismatched store or load ran");

  chk_full_clear: assert property ( // R11
    @(posedge ref_clk) disable iff (sys_rst)
    in_check && done_pulse == '0 |=> !cell_full)
    else $error("full flag not cleared by address check");

  chk_empty_hold: assert property ( // R11
    @(posedge ref_clk) disable iff (sys_rst)
    in_check && !id_match && cell_empty |=> cell_empty)
    else $error("empty flag cleared without a match");

  chk_crc_flag: assert property ( // R14
    @(posedge ref_clk) disable iff (sys_rst)
    s_hdr_cmd |=> header_check_error_n == $past(crc_ok) && control_data_oe == ctl_enabled)
    else $error("header check flag or answer wrong");

  chk_event_full: assert property ( // R21
    @(posedge ref_clk) disable iff (sys_rst)
    |done_pulse |=> cell_full ##0 (pending != '0))
    else $error("completed cell not reported");

  chk_hiz_oe: assert property ( // R6
    @(posedge ref_clk) disable iff (sys_rst)
    output_enable_n || config_word[CFG_CTL_OFF_BIT] |-> !control_data_oe && !header_check_error_oe)
    else $error("outputs driven while disabled");

  // Store and load handshake, status answer and event bookkeeping
  sequence s_load_match;
    is_load ##1 id_match;
  endsequence

  chk_go_only_check: assert property ( // R10
    @(posedge ref_clk) disable iff (sys_rst) !in_check |=> !memory_cycle_go)
    else $error("memory cycle outside an address check");

  chk_load_with_go: assert property ( // R10
    @(posedge ref_clk) disable iff (sys_rst) memory_cycle_load |-> memory_cycle_go)
    else $error("load flag without a memory cycle");

  chk_load_go: assert property ( // R10
    @(posedge ref_clk) disable iff (sys_rst) s_load_match |=> memory_cycle_load)
    else $error("matched load not flagged");

  chk_store_not_load: assert property ( // R10
    @(posedge ref_clk) disable iff (sys_rst) is_store |=> ##1 !memory_cycle_load)
    else $error("store flagged as load");

  chk_store_consume: assert property ( // R10
    @(posedge ref_clk) disable iff (sys_rst)
    store_hit && pending != '0 && done_pulse == '0 |=> pending != $past(pending))
    else $error("matched store left pending cells alone");

  chk_empty_clear: assert property ( // R11
    @(posedge ref_clk) disable iff (sys_rst) check_hit && !last_store |=> !cell_empty)
    else $error("empty flag kept after a match");

  chk_empty_set: assert property ( // R11
    @(posedge ref_clk) disable iff (sys_rst) last_store && pending == '0 |=> cell_empty)
    else $error("empty flag not set after last store");

  chk_status_read: assert property ( // R13
    @(posedge ref_clk) disable iff (sys_rst)
    is_rd_stat |=> drive_data && control_data_out == $past(status_word))
    else $error("status answer wrong");

  chk_data_cycle: assert property ( // R4
    @(posedge ref_clk) disable iff (sys_rst)
    state != ST_IDLE |=> state == ST_IDLE && !drive_data)
    else $error("command taken in a data cycle");

  chk_ctl_pin_off: assert property ( // R7
    @(posedge ref_clk) disable iff (sys_rst)
    control_output_enable_n |-> !control_data_oe && !header_check_error_oe)
    else $error("control outputs driven with pin high");

  chk_pending_set: assert property ( // R21
    @(posedge ref_clk) disable iff (sys_rst)
    done_pulse != '0 |=> (pending & $past(done_pulse)) == $past(done_pulse))
    else $error("completed cell not marked pending");

  chk_busy_set: assert property ( // R21
    @(posedge ref_clk) disable iff (sys_rst)
    start_pulse != '0 |=> (rx_busy & $past(start_pulse)) == $past(start_pulse))
    else $error("started cell not marked busy");
endmodule
`default_nettype wire

// ===== sim/cell_source_model.sv
// Line-side cell sources driving the eight receive ports.
// Assumes the bench calls its tasks one at a time; port clocks idle low.
`default_nettype none
module cell_source_model (
  output logic [7:0] port_clk,
  output logic [7:0] port_frame,
  output logic [31:0] port_data
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    port_clk = 8'h00;
    port_frame = 8'h00;
    port_data = 32'h0000_0000;
  end

  // One 15 ns period on the chosen port clocks
  task automatic tick(input logic [7:0] mask);
    #7.5 port_clk = mask;
    #7.5 port_clk = 8'h00;
  endtask

  task automatic pulse_all(input int n);
    repeat (n) tick(8'hFF);
  endtask

  // Frame leads by one edge; clock stands still outside the cell
  task automatic send_cell(input int p, input logic [39:0] hdr, input int nib, input int hold);
    logic [7:0] m;
    logic [3:0] v;
    m = 8'h01 << p;
    v = 4'h0;
    port_frame[p] = 1'b1;
    tick(m);
    port_frame[p] = 1'b0;
    for (int i = 0; i < nib; i++) begin
      v = (i < 10) ? hdr[39-4*i -: 4] : 4'(i * 7 + p);
      port_data[4*p +: 4] = v;
      if (i == hold) begin
        #100;
      end
      tick(m);
    end
    // Released lines flip so a late sample shows up
    port_data[4*p +: 4] = ~v;
    tick(m);
  endtask
endmodule
`default_nettype wire

// ===== sim/cell_switch_memory_ports_bench.sv
// Self-checking bench for the control port and receive ports.
// Assumes cell_source_model plays the line side of every port.
`default_nettype none
module cell_switch_memory_ports_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import cell_mem_pkg::*;
  logic ref_clk, sys_rst, chip_select_n, control_data_oe, header_check_error_n;
  logic header_check_error_oe, output_enable_n, control_output_enable_n, add_dummy_byte;
  logic cell_full, cell_empty, memory_cycle_go, memory_cycle_load;
  logic [5:0] command_bus;
  logic [31:0] control_data_in, control_data_out, port_data, seed, rd, cfg;
  logic [7:0] port_clk, port_frame;
  logic [3:0] chip_id_pins, id_or, id;
  logic [39:0] hdr;
  logic [2:0] code;
  logic saw_oe, saw_go, saw_load, narrow;
  int errors, check_count, cycles, p, len;

  cell_switch_memory_ports cell_switch_memory_ports_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .chip_select_n(chip_select_n),
    .command_bus(command_bus), .control_data_in(control_data_in),
    .control_data_out(control_data_out), .control_data_oe(control_data_oe),
    .header_check_error_n(header_check_error_n),
    .header_check_error_oe(header_check_error_oe), .output_enable_n(output_enable_n),
    .control_output_enable_n(control_output_enable_n), .chip_id_pins(chip_id_pins),
    .input_port_clock(port_clk), .input_cell_frame(port_frame),
    .input_nibble_data(port_data), .add_dummy_byte(add_dummy_byte),
    .cell_full(cell_full), .cell_empty(cell_empty),
    .memory_cycle_go(memory_cycle_go), .memory_cycle_load(memory_cycle_load)
  );

  cell_source_model cell_source_model_inst (
    .port_clk(port_clk), .port_frame(port_frame), .port_data(port_data)
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Ceiling well above six cells plus commands
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      $display("mismatch at %0t: timeout", $time);
      results();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 32; i++) begin
      s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    end
    return s;
  endfunction

  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ HEC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  function automatic int nibbles(input logic [2:0] c);
    return (c > CELL_CODE_MAX) ? 112 : 2 * (52 + int'(c));
  endfunction

  task automatic check_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %b", $time, what, got);
    end
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Command cycle, then data cycle, then watch the answers for four cycles
  task automatic cmd(input logic cs_n, input logic [5:0] c, input logic [31:0] d0,
                     input logic [31:0] d1);
    @(negedge ref_clk);
    chip_select_n = cs_n;
    command_bus = c;
    control_data_in = d0;
    @(negedge ref_clk);
    chip_select_n = 1'b1;
    command_bus = CMD_NOP;
    control_data_in = d1;
    saw_oe = 1'b0;
    saw_go = 1'b0;
    saw_load = 1'b0;
    repeat (4) begin
      if (control_data_oe === 1'b1) begin
        saw_oe = 1'b1;
        rd = control_data_out;
      end
      saw_go = saw_go | (memory_cycle_go === 1'b1);
      saw_load = saw_load | (memory_cycle_load === 1'b1);
      @(negedge ref_clk);
    end
  endtask

  // Port domains only see new settings while their clocks run
  task automatic set_cfg(input logic [31:0] c);
    cmd(1'b0, CMD_WR_CONFIG, 32'h0000_0000, c);
    cell_source_model_inst.pulse_all(3);
    @(negedge ref_clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    seed = 32'ha29e_a0fb;
    rd = 32'h0000_0000;
    sys_rst = 1'b0;
    output_enable_n = 1'b1;
    control_output_enable_n = 1'b1;
    chip_select_n = 1'b1;
    command_bus = CMD_NOP;
    control_data_in = 32'h0000_0000;
    chip_id_pins = 4'h0;
    add_dummy_byte = 1'b0;
    // Raised after time zero so every reset process sees the edge
    #1 sys_rst = 1'b1;
    fork
      cell_source_model_inst.pulse_all(4);
      repeat (10) @(posedge ref_clk);
    join
    @(negedge ref_clk);
    sys_rst = 1'b0;
    cell_source_model_inst.pulse_all(3);
    @(negedge ref_clk);
    check_bit(control_data_oe, 1'b0, "read drive after reset");
    check_bit(header_check_error_n, 1'b1, "error flag after reset");
    check_bit(cell_full, 1'b0, "full after reset");
    check_bit(cell_empty, 1'b1, "empty after reset");
    output_enable_n = 1'b0;
    control_output_enable_n = 1'b0;
    cmd(1'b0, CMD_RD_STATUS, 32'h0000_0000, 32'h0000_0000);
    check_bit(saw_oe, 1'b0, "status drive with control off");
    check_bit(header_check_error_oe, 1'b0, "error drive with control off");
    $display("test reset done");
    seed = lfsr(seed);
    id_or = seed[3:0];
    set_cfg({2'b00, id_or, 26'h0_00FF});
    for (int i = 0; i < 5; i++) begin
      @(negedge ref_clk);
      output_enable_n = i[1];
      control_output_enable_n = i[0];
      #1;
      check_bit(header_check_error_oe, i == 0 || i == 4, "error pin drive");
      cmd(i == 4, CMD_RD_STATUS, 32'h0000_0000, 32'h0000_0000);
      check_bit(saw_oe, i == 0, "status drive");
    end
    $display("test enables done");
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      p = (k == 0) ? 7 : int'(seed[2:0]);
      code = seed[10:8];
      narrow = (k == 5);
      add_dummy_byte = narrow;
      set_cfg({2'b00, id_or, 13'h0000, narrow, 1'b0, code, 8'hFF});
      hdr[39:8] = lfsr(seed);
      hdr[7:0] = crc8(hdr[39:8]) ^ {7'h00, k[0]};
      len = nibbles(code) - (narrow ? 2 : 0);
      cell_source_model_inst.send_cell(p, hdr, len, (k == 1) ? 40 : -1);
      repeat (8) @(negedge ref_clk);
      check_bit(cell_full, 1'b1, "full after cell");
      if (narrow) begin
        check_bit(cell_full, 1'b1, "cell with dummy byte");
      end
      cmd(1'b0, CMD_HDR_CRC, 32'(p), seed);
      check_bit(saw_oe, 1'b1, "header read drive");
      check_word(rd, hdr[39:8], "header bytes");
      check_bit(header_check_error_n, ~k[0], "header check flag");
      cmd(1'b0, CMD_RD_STATUS, 32'h0000_0000, 32'h0000_0000);
      check_bit(rd[STAT_PEND_LSB + p], 1'b1, "pending cell");
      chip_id_pins = seed[15:12];
      repeat (3) @(negedge ref_clk);
      id = seed[15:12] | id_or;
      cmd(1'b0, CMD_STORE, 32'h0000_0000, 32'(id ^ 4'h8) << 13);
      check_bit(saw_go, 1'b0, "store with other id");
      check_bit(cell_full, 1'b0, "full after check");
      check_bit(cell_empty, 1'b1, "empty after mismatch");
      // Load first: a matched load clears empty, the last store sets it again
      cmd(1'b0, CMD_LOAD, 32'h0000_0000, 32'(id) << 13);
      check_bit(saw_load, 1'b1, "matched load");
      check_bit(cell_empty, 1'b0, "empty cleared by match");
      cmd(1'b0, CMD_STORE, 32'h0000_0000, 32'(id) << 13);
      check_bit(saw_go, 1'b1, "matched store");
      check_bit(saw_load, 1'b0, "store flagged as load");
      check_bit(cell_empty, 1'b1, "empty after last store");
      $display("test cell %0d done", k);
    end
    results();
  end
endmodule
`default_nettype wire
